/* File: core/cts_defs.svh */
// offsets, field positions, reset values and sizes of the trigger gate block
`ifndef CTS_DEFS_SVH
`define CTS_DEFS_SVH
`define CTS_NUM_TRIG 9
`define CTS_NUM_CHAN 4
`define CTS_NUM_EDGE 6
`define CTS_NUM_MAP 18
`define CTS_OUT_IDX_BASE 5'h09
`define CTS_EDGE_LSB 1
`define CTS_EDGE_MSB 6
`define CTS_TRACE_MSB 3
`define CTS_MON_LSB 4
`define CTS_OFS_APP_SET 12'h014
`define CTS_OFS_APP_CLEAR 12'h018
`define CTS_OFS_APP_PULSE 12'h01c
`define CTS_OFS_IN_EN 12'h020
`define CTS_OFS_OUT_EN 12'h0a0
`define CTS_EN_SPAN 12'h024
`define CTS_OFS_TRIGIN_ST 12'h130
`define CTS_OFS_TRIGOUT_ST 12'h134
`define CTS_OFS_CHIN_ST 12'h138
`define CTS_OFS_CHOUT_ST 12'h13c
`define CTS_OFS_GATE 12'h140
`define CTS_OFS_EDGE_CTL 12'h144
`define CTS_GATE_RST 4'hf
`define CTS_EDGE_RST 6'h00
`define CTS_MAP_RST 4'h0
`define CTS_APP_RST 4'h0
`endif

/* File: core/cts_pkg.sv */
// types shared by the trigger gate block
package cts_pkg;
   typedef logic [3:0] cts_chan_t;
   typedef logic [8:0] cts_trig_t;
   typedef logic [5:0] cts_edge_t;
   typedef logic [4:0] cts_map_idx_t;
   typedef logic [35:0] cts_map_vec_t;
endpackage : cts_pkg

/* File: core/cts_edge_det.sv */
// selectable rising-edge detectors for core-domain trigger outputs
`timescale 1ns/10ps
`include "cts_defs.svh"
module cts_edge_det (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // levels and enables
   input wire cts_pkg::cts_edge_t lvl,
   input wire cts_pkg::cts_edge_t en,
   // detected events or passed levels
   output cts_pkg::cts_edge_t det_ff
);
   cts_pkg::cts_edge_t prev_ff;
   cts_pkg::cts_edge_t nxt_det;

   for (genvar i = 0; i < `CTS_NUM_EDGE; i++) begin : g_bit
      // one-cycle pulse per rising edge, or the level itself
      assign nxt_det[i] = en[i] ? (lvl[i] & ~prev_ff[i]) : lvl[i];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= '0;
         det_ff <= '0;
      end else begin
         prev_ff <= lvl;
         det_ff <= nxt_det;
      end
   end

   edge_pulse_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (en[0] && $rose(lvl[0])) |=> det_ff[0] ##1 !det_ff[0] || !en[0]
   ) else $error("trace edge pulse missing or too long");

   edge_single_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (en[5] && lvl[5] && prev_ff[5]) |=> !det_ff[5]
   ) else $error("monitor event repeated on held level");

   edge_pass_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !en[2] |=> det_ff[2] == $past(lvl[2])
   ) else $error("level not passed when detection off");

   edge_seen_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      en[4] && $rose(lvl[4]) ##1 det_ff[4]
   );
endmodule : cts_edge_det

/* File: core/cts_map_regs.sv */
// trigger-to-channel and channel-to-trigger enable register store
`timescale 1ns/10ps
`include "cts_defs.svh"
module cts_map_regs (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // write port
   input wire logic wr_en,
   input wire cts_pkg::cts_map_idx_t wr_idx,
   input wire cts_pkg::cts_chan_t wr_data,
   // read port
   input wire cts_pkg::cts_map_idx_t rd_idx,
   output cts_pkg::cts_chan_t rd_data_ff,
   // enables, four bits per trigger
   output cts_pkg::cts_map_vec_t in_en,
   output cts_pkg::cts_map_vec_t out_en
);
   cts_pkg::cts_chan_t entry_ff [`CTS_NUM_MAP];
   cts_pkg::cts_chan_t nxt_rd;

   for (genvar i = 0; i < `CTS_NUM_MAP; i++) begin : g_entry
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            entry_ff[i] <= `CTS_MAP_RST;
         end else if (wr_en && wr_idx == 5'(i)) begin
            entry_ff[i] <= wr_data;
         end
      end
      if (i < `CTS_NUM_TRIG) begin : g_in
         assign in_en[i*4 +: 4] = entry_ff[i];
      end else begin : g_out
         assign out_en[(i-`CTS_NUM_TRIG)*4 +: 4] = entry_ff[i];
      end
   end

   assign nxt_rd = (rd_idx < 5'(`CTS_NUM_MAP)) ? entry_ff[rd_idx] : 4'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data_ff <= 4'h0;
      end else begin
         rd_data_ff <= nxt_rd;
      end
   end
endmodule : cts_map_regs

/* File: core/cts_gate_regs.sv */
// cross-trigger status, channel gate and edge control registers on apb
`timescale 1ns/10ps
`include "cts_defs.svh"
// Operation
// - trigger input status reads raw levels of nine trigger inputs in [8:0]
// - trigger output status reads nine trigger output states, zero after reset
// - channel input status reads raw levels of four channel inputs in [3:0]
// - channel output status reads four channel output states, zero after reset
// - gate bit n enables channel output n; zero blocks its events
// - gated channel never leaves, but still drives local trigger outputs
// - software-asserted channels drive mapped trigger outputs even while gated
// - edge control holds six enables for trigger outputs one to six
// - edge detection selectable per core output; off passes level unchanged
// - with detection on, one monitor event per rising edge
// - with detection on, trace input high one cycle per rising edge
// - trigger input raises channel n only if its enable bit n is set
// - trigger output driven by channel n only if its enable bit n is set
module cts_gate_regs (
   // apb clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // core trigger side
   input wire cts_pkg::cts_trig_t trigger_inputs,
   output cts_pkg::cts_trig_t trigger_outputs,
   output logic [3:0] trace_inputs,
   output logic [1:0] monitor_events,
   // matrix side
   input wire cts_pkg::cts_chan_t channel_inputs,
   output cts_pkg::cts_chan_t channel_outputs
);
   // registers
   cts_pkg::cts_chan_t gate_ff;
   cts_pkg::cts_edge_t edge_ctl_ff;
   cts_pkg::cts_chan_t app_set_ff;
   cts_pkg::cts_chan_t pulse_ff;
   cts_pkg::cts_chan_t chan_out_ff;
   cts_pkg::cts_trig_t trig_out_ff;
   logic [31:0] rdata_ff;
   logic map_rd_ff;
   logic slverr_ff;
   // next values and decode
   cts_pkg::cts_chan_t nxt_app_set;
   cts_pkg::cts_chan_t nxt_pulse;
   cts_pkg::cts_trig_t nxt_trig_out;
   logic [31:0] nxt_rdata;
   logic setup;
   logic wr;
   logic aligned;
   logic hit_set;
   logic hit_clear;
   logic hit_pulse;
   logic hit_in_en;
   logic hit_out_en;
   logic hit_map;
   logic hit_trigin;
   logic hit_trigout;
   logic hit_chin;
   logic hit_chout;
   logic hit_gate;
   logic hit_edge;
   logic hit_any;
   logic [11:0] in_off;
   logic [11:0] out_off;
   cts_pkg::cts_map_idx_t map_idx;
   cts_pkg::cts_chan_t map_rd;
   cts_pkg::cts_map_vec_t in_en;
   cts_pkg::cts_map_vec_t out_en;
   cts_pkg::cts_chan_t trig_evt;
   cts_pkg::cts_chan_t chan_evt;
   cts_pkg::cts_chan_t chan_local;
   cts_pkg::cts_edge_t edge_det;

   // apb phases: zero wait, every access ends in its first access cycle
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign pready = 1'b1;

   // address decode
   assign aligned = paddr[1:0] == 2'h0;
   assign in_off = paddr - `CTS_OFS_IN_EN;
   assign out_off = paddr - `CTS_OFS_OUT_EN;
   assign hit_set = aligned && paddr == `CTS_OFS_APP_SET;
   assign hit_clear = aligned && paddr == `CTS_OFS_APP_CLEAR;
   assign hit_pulse = aligned && paddr == `CTS_OFS_APP_PULSE;
   assign hit_in_en = aligned && paddr >= `CTS_OFS_IN_EN
      && in_off < `CTS_EN_SPAN;
   assign hit_out_en = aligned && paddr >= `CTS_OFS_OUT_EN
      && out_off < `CTS_EN_SPAN;
   assign hit_map = hit_in_en || hit_out_en;
   assign hit_trigin = aligned && paddr == `CTS_OFS_TRIGIN_ST;
   assign hit_trigout = aligned && paddr == `CTS_OFS_TRIGOUT_ST;
   assign hit_chin = aligned && paddr == `CTS_OFS_CHIN_ST;
   assign hit_chout = aligned && paddr == `CTS_OFS_CHOUT_ST;
   assign hit_gate = aligned && paddr == `CTS_OFS_GATE;
   assign hit_edge = aligned && paddr == `CTS_OFS_EDGE_CTL;
   assign hit_any = hit_set || hit_clear || hit_pulse || hit_map
      || hit_trigin || hit_trigout || hit_chin || hit_chout
      || hit_gate || hit_edge;
   assign map_idx = hit_in_en ? in_off[6:2]
      : 5'(out_off[6:2] + `CTS_OUT_IDX_BASE);

   cts_map_regs u_map (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr && hit_map),
      .wr_idx(map_idx),
      .wr_data(pwdata[3:0]),
      .rd_idx(map_idx),
      .rd_data_ff(map_rd),
      .in_en(in_en),
      .out_en(out_en)
   );

   // read mux, status words padded with zero above the field
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (hit_trigin) begin
         nxt_rdata = {23'h0, trigger_inputs};
      end else if (hit_trigout) begin
         nxt_rdata = {23'h0, trig_out_ff};
      end else if (hit_chin) begin
         nxt_rdata = {28'h0, channel_inputs};
      end else if (hit_chout) begin
         nxt_rdata = {28'h0, chan_out_ff};
      end else if (hit_gate) begin
         nxt_rdata = {28'h0, gate_ff};
      end else if (hit_edge) begin
         nxt_rdata = {26'h0, edge_ctl_ff};
      end else if (hit_set) begin
         nxt_rdata = {28'h0, app_set_ff};
      end
   end

   // read data and error captured in setup, shown through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_ff <= 32'h0000_0000;
         map_rd_ff <= 1'b0;
         slverr_ff <= 1'b0;
      end else if (setup) begin
         rdata_ff <= nxt_rdata;
         map_rd_ff <= hit_map;
         slverr_ff <= !hit_any;
      end
   end

   assign prdata = map_rd_ff ? {28'h0, map_rd} : rdata_ff;
   assign pslverr = slverr_ff && psel && penable;

   // control registers; status offsets have no write path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_ff <= `CTS_GATE_RST;
         edge_ctl_ff <= `CTS_EDGE_RST;
      end else if (wr && hit_gate) begin
         gate_ff <= pwdata[3:0];
      end else if (wr && hit_edge) begin
         edge_ctl_ff <= pwdata[5:0];
      end
   end

   // software channel set, clear and self-clearing pulse
   assign nxt_app_set = (wr && hit_set) ? (app_set_ff | pwdata[3:0])
      : (wr && hit_clear) ? (app_set_ff & ~pwdata[3:0]) : app_set_ff;
   assign nxt_pulse = (wr && hit_pulse) ? pwdata[3:0] : 4'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         app_set_ff <= `CTS_APP_RST;
         pulse_ff <= `CTS_APP_RST;
      end else begin
         app_set_ff <= nxt_app_set;
         pulse_ff <= nxt_pulse;
      end
   end

   // channel events from enabled trigger inputs
   for (genvar c = 0; c < `CTS_NUM_CHAN; c++) begin : g_chan
      cts_pkg::cts_trig_t col;
      for (genvar t = 0; t < `CTS_NUM_TRIG; t++) begin : g_col
         assign col[t] = in_en[t*4 + c];
      end
      assign trig_evt[c] = |(trigger_inputs & col);
   end

   assign chan_evt = trig_evt | app_set_ff | pulse_ff;
   // local view ignores the gate so own outputs still fire
   assign chan_local = chan_evt | channel_inputs;

   for (genvar t = 0; t < `CTS_NUM_TRIG; t++) begin : g_trig
      assign nxt_trig_out[t] = |(chan_local & out_en[t*4 +: 4]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_out_ff <= 4'h0;
         trig_out_ff <= 9'h000;
      end else begin
         chan_out_ff <= chan_evt & gate_ff;
         trig_out_ff <= nxt_trig_out;
      end
   end

   assign channel_outputs = chan_out_ff;
   assign trigger_outputs = trig_out_ff;

   // core-domain outputs one to six through selectable edge detection
   cts_edge_det u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .lvl(trig_out_ff[`CTS_EDGE_MSB:`CTS_EDGE_LSB]),
      .en(edge_ctl_ff),
      .det_ff(edge_det)
   );

   assign trace_inputs = edge_det[`CTS_TRACE_MSB:0];
   assign monitor_events = edge_det[`CTS_NUM_EDGE-1:`CTS_MON_LSB];

   trigin_read_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `CTS_OFS_TRIGIN_ST)
      |=> prdata == {23'h0, $past(trigger_inputs)}
   ) else $error("trigger input status read wrong");

   trigout_read_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `CTS_OFS_TRIGOUT_ST)
      |=> prdata == {23'h0, $past(trigger_outputs)}
   ) else $error("trigger output status read wrong");

   chin_read_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `CTS_OFS_CHIN_ST)
      |=> prdata == {28'h0, $past(channel_inputs)}
   ) else $error("channel input status read wrong");

   chout_read_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == `CTS_OFS_CHOUT_ST)
      |=> prdata == {28'h0, $past(channel_outputs)}
   ) else $error("channel output status read wrong");

   gate_block_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      !gate_ff[0] |=> !channel_outputs[0]
   ) else $error("gated channel reached the matrix");

   gated_local_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (!gate_ff[1] && app_set_ff[1] && out_en[13]) |=> trigger_outputs[3]
   ) else $error("gated software channel missed local trigger");

   trig_map_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (trigger_inputs[0] && in_en[0] && gate_ff[0]) |=> channel_outputs[0]
   ) else $error("enabled trigger input raised no channel event");

   out_mask_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (out_en[3:0] == 4'h0) |=> !trigger_outputs[0]
   ) else $error("trigger output driven by disabled channel");

   ro_write_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && (hit_trigin || hit_chout)) |=> $stable(gate_ff)
      && $stable(edge_ctl_ff) && $stable(app_set_ff)
   ) else $error("status write changed control state");

   pulse_once_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr && hit_pulse) |=> pulse_ff == $past(pwdata[3:0]) ##1 pulse_ff == 4'h0
      || (pulse_ff != 4'h0 && $past(wr && hit_pulse))
   ) else $error("software pulse not one cycle");

   gate_write_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      wr && hit_gate && pwdata[3:0] == 4'h0
   );

   status_read_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      setup && !pwrite && hit_trigin ##1 penable
   );

   gated_local_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      !gate_ff[0] && chan_evt[0] ##1 trigger_outputs != 9'h000
   );

   unmapped_c: cover property (
      @(posedge pclk) disable iff (!presetn)
      pslverr
   );
endmodule : cts_gate_regs

/* File: bench/cts_matrix_model.sv */
// behavioural cross-trigger matrix feeding the channel inputs
`timescale 1ns/10ps
module cts_matrix_model (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench control
   input wire cts_pkg::cts_chan_t drive_val,
   input wire logic echo_en,
   input wire logic slow,
   // matrix side of the block
   input wire cts_pkg::cts_chan_t channel_outputs,
   output cts_pkg::cts_chan_t channel_inputs
);
   cts_pkg::cts_chan_t stage_ff;
   cts_pkg::cts_chan_t late_ff;
   cts_pkg::cts_chan_t nxt_stage;
   // other interfaces plus the echo of this one's own gated channels
   assign nxt_stage = drive_val | (echo_en ? channel_outputs : 4'h0);
   // slow mode adds one cycle of matrix latency
   assign channel_inputs = slow ? late_ff : stage_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_ff <= 4'h0;
         late_ff <= 4'h0;
      end else begin
         stage_ff <= nxt_stage;
         late_ff <= stage_ff;
      end
   end
endmodule : cts_matrix_model

/* File: bench/test_cts_gate_regs.sv */
// self-checking bench for the cross-trigger status and gate registers
`timescale 1ns/10ps
module test_cts_gate_regs;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic rerr, echo_en, slow;
   cts_pkg::cts_trig_t trigger_inputs, trigger_outputs;
   cts_pkg::cts_chan_t channel_inputs, channel_outputs, drive_val;
   logic [3:0] trace_inputs;
   logic [1:0] monitor_events;
   logic [5:0] core_evts;
   int bad_count = 0;
   int n_checks = 0;

   cts_gate_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .trigger_inputs(trigger_inputs), .trigger_outputs(trigger_outputs),
      .trace_inputs(trace_inputs), .monitor_events(monitor_events),
      .channel_inputs(channel_inputs), .channel_outputs(channel_outputs));
   cts_matrix_model matrix (.pclk(pclk), .presetn(presetn),
      .drive_val(drive_val), .echo_en(echo_en), .slow(slow),
      .channel_outputs(channel_outputs), .channel_inputs(channel_inputs));

   // trace inputs in bits 3:0, monitor events in bits 5:4
   assign core_evts = {monitor_events, trace_inputs};

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task print_verdict;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      logic rdy;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // answer taken at the edge where pready is sampled high
      do begin
         @(posedge pclk);
         rdy = pready;
         rdata = prdata;
         rerr = pslverr;
         n++;
      end while (rdy !== 1'b1 && n < 40);
      psel <= 1'b0;
      penable <= 1'b0;
      if (rdy !== 1'b1) begin
         bad_count++;
         $display("Error at %0t: no bus answer", $time);
         print_verdict();
      end
   endtask : apb

   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk({31'h0, rerr}, 32'h0);
      chk(rdata, exp);
   endtask : rd_chk

   task settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : settle

   task t_reset;
      rd_chk(12'h134, 32'h0);
      rd_chk(12'h13c, 32'h0);
      rd_chk(12'h140, 32'h0000000f);
      rd_chk(12'h144, 32'h0);
      chk({19'h0, trigger_outputs, channel_outputs}, 32'h0);
      chk({26'h0, core_evts}, 32'h0);
      $display("test reset values done");
   endtask : t_reset

   task t_status;
      @(posedge pclk);
      trigger_inputs <= 9'h1a5;
      drive_val <= 4'ha;
      settle(4);
      rd_chk(12'h130, 32'h000001a5);
      rd_chk(12'h138, 32'h0000000a);
      apb(1'b1, 12'h130, 32'hffffffff);
      rd_chk(12'h130, 32'h000001a5);
      apb(1'b1, 12'h13c, 32'hffffffff);
      rd_chk(12'h13c, 32'h0);
      apb(1'b1, 12'h144, 32'hffffffff);
      rd_chk(12'h144, 32'h0000003f);
      apb(1'b1, 12'h144, 32'h0);
      apb(1'b0, 12'h200, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      chk(rdata, 32'h0);
      @(posedge pclk);
      trigger_inputs <= 9'h0;
      drive_val <= 4'h0;
      $display("test status registers done");
   endtask : t_status

   task t_route;
      apb(1'b1, 12'h0a8, 32'h1);
      @(posedge pclk);
      trigger_inputs <= 9'h001;
      settle(4);
      chk({28'h0, channel_outputs}, 32'h0);
      apb(1'b1, 12'h020, 32'h1);
      settle(4);
      chk({28'h0, channel_outputs}, 32'h1);
      chk({23'h0, trigger_outputs}, 32'h4);
      rd_chk(12'h13c, 32'h1);
      rd_chk(12'h134, 32'h4);
      echo_en <= 1'b1;
      settle(4);
      rd_chk(12'h138, 32'h1);
      echo_en <= 1'b0;
      apb(1'b1, 12'h140, 32'he);
      settle(4);
      chk({28'h0, channel_outputs}, 32'h0);
      chk({23'h0, trigger_outputs}, 32'h4);
      @(posedge pclk);
      trigger_inputs <= 9'h0;
      slow <= 1'b1;
      drive_val <= 4'h1;
      settle(5);
      chk({23'h0, trigger_outputs}, 32'h4);
      drive_val <= 4'h0;
      slow <= 1'b0;
      apb(1'b1, 12'h0a8, 32'h0);
      apb(1'b1, 12'h020, 32'h0);
      $display("test routing and gate done");
   endtask : t_route

   task t_app;
      int hi;
      apb(1'b1, 12'h140, 32'h0);
      apb(1'b1, 12'h0ac, 32'h2);
      apb(1'b1, 12'h014, 32'h2);
      settle(3);
      chk({23'h0, trigger_outputs}, 32'h8);
      chk({28'h0, channel_outputs}, 32'h0);
      rd_chk(12'h014, 32'h2);
      apb(1'b1, 12'h018, 32'h2);
      settle(3);
      chk({23'h0, trigger_outputs}, 32'h0);
      apb(1'b1, 12'h01c, 32'h2);
      hi = 0;
      repeat (8) begin
         settle(1);
         if (trigger_outputs[3] === 1'b1)
            hi++;
      end
      chk(hi, 1);
      apb(1'b1, 12'h0ac, 32'h0);
      apb(1'b1, 12'h140, 32'hf);
      $display("test software channels done");
   endtask : t_app

   task t_edge;
      logic [5:0] ctl;
      int cnt [6];
      apb(1'b1, 12'h024, 32'h2);
      for (int i = 1; i <= 6; i++)
         apb(1'b1, 12'h0a0 + 12'(4 * i), 32'h2);
      for (int p = 0; p < 2; p++) begin
         ctl = p ? 6'h2a : 6'h15;
         apb(1'b1, 12'h144, {26'h0, ctl});
         for (int k = 0; k < 6; k++)
            cnt[k] = 0;
         @(posedge pclk);
         trigger_inputs <= 9'h002;
         // count from the first edge so the early pulse is not missed
         for (int c = 1; c <= 14; c++) begin
            @(posedge pclk);
            if (c == 5)
               trigger_inputs <= 9'h0;
            #1;
            for (int k = 0; k < 6; k++)
               if (core_evts[k] === 1'b1)
                  cnt[k]++;
         end
         for (int k = 0; k < 4; k++)
            chk(cnt[k], ctl[k] ? 1 : 5);
         for (int k = 4; k < 6; k++)
            chk(cnt[k], ctl[k] ? 1 : 5);
      end
      $display("test edge detection done");
   endtask : t_edge

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      trigger_inputs = 9'h0;
      drive_val = 4'h0;
      echo_en = 1'b0;
      slow = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_status();
      t_route();
      t_app();
      t_edge();
      print_verdict();
   end
endmodule : test_cts_gate_regs
